/* File: design/asrcs_map.vh */
// register offsets, field positions, reset values and codes for the source/reference/clock select
`ifndef ASRCS_MAP_VH
`define ASRCS_MAP_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ASRCS_ADDR_W 4
`define ASRCS_OFF_SRC_REF_CLK 4'h0
`define ASRCS_OFF_CHAN 4'h1
`define ASRCS_OFF_BANDGAP 4'h2
`define ASRCS_OFF_PIN_ANALOG 4'h3
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASRCS_SRC_HI 7
`define ASRCS_SRC_LO 5
`define ASRCS_REF_HI 4
`define ASRCS_REF_LO 3
`define ASRCS_CKS_HI 2
`define ASRCS_CKS_LO 0
`define ASRCS_BG_BIT 3
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ASRCS_RST_SRC_REF_CLK 8'h00
`define ASRCS_RST_CHAN 4'h0
`define ASRCS_RST_BANDGAP 1'b0
`define ASRCS_RST_PIN_ANALOG 8'h00
// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define ASRCS_SRC_VDD_QUARTER 3'h4
`define ASRCS_SRC_GND_LO 3'h1
`define ASRCS_SRC_GND_HI 3'h3
`define ASRCS_REF_VDD 2'h1
`define ASRCS_REF_OPAMP 2'h2
`define ASRCS_MUX_EXT 2'h0
`define ASRCS_MUX_GND 2'h1
`define ASRCS_MUX_QUARTER 2'h2
`define ASRCS_REFSEL_PIN 2'h0
`define ASRCS_REFSEL_VDD 2'h1
`define ASRCS_REFSEL_OPAMP 2'h2
`endif

/* File: design/asrcs_clk_div.v */
// converter clock prescaler: one-cycle enable at system clock divided by a power of two
`default_nettype none
module asrcs_clk_div #(
    parameter SEL_W = 3
) (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire [SEL_W-1:0] div_sel_i,
    output reg conv_clk_en_o
);
    localparam CNT_W = (1 << SEL_W) - 1;

    reg [CNT_W-1:0] cnt_reg;
    reg [SEL_W-1:0] sel_seen_reg;
    wire [CNT_W-1:0] mask;

    // mask of low counter bits that must all be one for the divided tick
    assign mask = ({{(CNT_W-1){1'b0}}, 1'b1} << div_sel_i) - {{(CNT_W-1){1'b0}}, 1'b1};

    // free counter; restarts on a divider change so the new rate begins cleanly
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cnt_reg <= {CNT_W{1'b0}};
            sel_seen_reg <= {SEL_W{1'b0}};
            conv_clk_en_o <= 1'b0;
        end else begin
            sel_seen_reg <= div_sel_i;
            if (sel_seen_reg != div_sel_i) begin
                cnt_reg <= {CNT_W{1'b0}};
                conv_clk_en_o <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                conv_clk_en_o <= ((cnt_reg & mask) == mask); // R11
            end
        end
    end
endmodule
`default_nettype wire

/* File: design/asrcs_pin_share.v */
// per-pin override when a shared pin becomes an analog converter input
`default_nettype none
module asrcs_pin_share #(
    parameter N_PINS = 8
) (
    input wire [N_PINS-1:0] analog_sel_i,
    input wire [N_PINS-1:0] gpio_oe_n_i,
    input wire [N_PINS-1:0] gpio_dout_i,
    input wire [N_PINS-1:0] pullup_en_i,
    output wire [N_PINS-1:0] pin_oe_n_o,
    output wire [N_PINS-1:0] pin_dout_o,
    output wire [N_PINS-1:0] pin_pullup_o,
    output wire [N_PINS-1:0] pin_digital_in_en_o
);
    genvar i;
    generate
        for (i = 0; i < N_PINS; i = i + 1) begin : g_pin
            // analog pin: driver off whatever the direction control says
            assign pin_oe_n_o[i] = gpio_oe_n_i[i] | analog_sel_i[i]; // R16
            assign pin_dout_o[i] = gpio_dout_i[i] & ~analog_sel_i[i]; // R14
            assign pin_pullup_o[i] = pullup_en_i[i] & ~analog_sel_i[i]; // R15
            assign pin_digital_in_en_o[i] = ~analog_sel_i[i]; // R14
        end
    endgenerate
endmodule
`default_nettype wire

/* File: design/asrcs_top.v */
// converter source, reference and clock selection with bandgap and pin-share control
// ----------------------------------------------------------------
// Function
// R1: source 000 or 101-111 routes external channel chosen by channel select
// R2: source 001-011 grounds the converter input
// R3: source 100 feeds converter from quarter supply
// R4: channel codes 0000-0111 pick pins 0,2-6; 1000-1111 pick none
// R5: software sets channel 1000-1111 before choosing quarter supply
// R6: reference code 01 uses internal supply
// R7: reference code 10 uses opamp output
// R8: reference code 00 or 11 uses external reference pin
// R9: software keeps reference pin unconfigured while internal reference used
// R10: software disables other pin functions when external reference chosen
// R11: clock field divides system clock by two to the field value
// R12: bandgap on when low-voltage reset enabled or control bit 3 set
// R13: bandgap register bits 7-4 and 2-0 read zero
// R14: analog-selected pin loses digital and alternate functions
// R15: analog-selected pin loses its pull-high
// R16: analog-selected pin ignores direction control
// R17: select field changes reach converter controls next cycle after write
// ----------------------------------------------------------------
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`default_nettype none
`include "asrcs_map.vh"
module asrcs_top #(
    parameter N_PINS = 8
) (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire [`ASRCS_ADDR_W-1:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire low_voltage_reset_en_i,
    input wire [N_PINS-1:0] gpio_oe_n_i,
    input wire [N_PINS-1:0] gpio_dout_i,
    input wire [N_PINS-1:0] pullup_en_i,
    output wire [N_PINS-1:0] pin_oe_n_o,
    output wire [N_PINS-1:0] pin_dout_o,
    output wire [N_PINS-1:0] pin_pullup_o,
    output wire [N_PINS-1:0] pin_digital_in_en_o,
    output reg [1:0] input_mux_sel_o,
    output reg [7:0] analog_channel_pin_o,
    output reg [1:0] reference_sel_o,
    output wire conv_clk_en_o,
    output reg bandgap_enable_o
);
    // ----------------------------------------------------------------
    // decode functions
    // ----------------------------------------------------------------
    // source field to converter input mux code
    // 000 and 101-111 all fall through to the external source
    function [1:0] src_decode;
        input [2:0] src;
        begin
            if (src == `ASRCS_SRC_VDD_QUARTER) begin
                src_decode = `ASRCS_MUX_QUARTER; // R3
            end else if (src >= `ASRCS_SRC_GND_LO && src <= `ASRCS_SRC_GND_HI) begin
                src_decode = `ASRCS_MUX_GND; // R2
            end else begin
                src_decode = `ASRCS_MUX_EXT; // R1
            end
        end
    endfunction

    // channel code to one-hot pin switch; codes 1, 7 and the high half connect nothing
    // spelled out code by code so a reserved code can never close a switch by accident
    function [7:0] chan_decode;
        input [3:0] chan;
        begin
            case (chan)
                4'h0: begin
                    chan_decode = 8'h01; // R4
                end
                4'h2: begin
                    chan_decode = 8'h04; // R4
                end
                4'h3: begin
                    chan_decode = 8'h08; // R4
                end
                4'h4: begin
                    chan_decode = 8'h10; // R4
                end
                4'h5: begin
                    chan_decode = 8'h20; // R4
                end
                4'h6: begin
                    chan_decode = 8'h40; // R4
                end
                default: begin
                    chan_decode = 8'h00; // R4
                end
            endcase
        end
    endfunction

    // reference field to reference switch code; 00 and 11 both mean the reference pin
    function [1:0] ref_decode;
        input [1:0] refsel;
        begin
            case (refsel)
                `ASRCS_REF_VDD: begin
                    ref_decode = `ASRCS_REFSEL_VDD; // R6
                end
                `ASRCS_REF_OPAMP: begin
                    ref_decode = `ASRCS_REFSEL_OPAMP; // R7
                end
                default: begin
                    ref_decode = `ASRCS_REFSEL_PIN; // R8
                end
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // register file
    reg [7:0] src_ref_clk_reg;
    reg [3:0] chan_reg;
    reg bandgap_ctrl_reg;
    reg [N_PINS-1:0] pin_analog_reg;
    wire [2:0] input_source_select;
    wire [1:0] reference_select;
    wire [2:0] converter_clock_divider_select;
    // per-register write enables and next values of the registered outputs
    wire wr_src_ref_clk;
    wire wr_chan;
    wire wr_bandgap;
    wire wr_pin_analog;
    reg [7:0] rdata_next;
    reg [1:0] input_mux_next;
    reg [7:0] analog_channel_pin_next;
    reg [1:0] reference_sel_next;
    reg bandgap_enable_next;

    // field slices of the source, reference and clock register
    assign input_source_select = src_ref_clk_reg[`ASRCS_SRC_HI:`ASRCS_SRC_LO];
    assign reference_select = src_ref_clk_reg[`ASRCS_REF_HI:`ASRCS_REF_LO];
    assign converter_clock_divider_select = src_ref_clk_reg[`ASRCS_CKS_HI:`ASRCS_CKS_LO];

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // one-cycle strobe, no wait; unmapped offsets match no enable and are dropped
    assign wr_src_ref_clk = reg_wr_i && (reg_addr_i == `ASRCS_OFF_SRC_REF_CLK);
    assign wr_chan = reg_wr_i && (reg_addr_i == `ASRCS_OFF_CHAN);
    assign wr_bandgap = reg_wr_i && (reg_addr_i == `ASRCS_OFF_BANDGAP);
    assign wr_pin_analog = reg_wr_i && (reg_addr_i == `ASRCS_OFF_PIN_ANALOG);

    // source, reference and clock fields; all eight bits are read/write
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            src_ref_clk_reg <= `ASRCS_RST_SRC_REF_CLK;
        end else if (wr_src_ref_clk) begin
            src_ref_clk_reg <= reg_wdata_i;
        end
    end

    // external channel code; the upper four bits of the write are dropped
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            chan_reg <= `ASRCS_RST_CHAN;
        end else if (wr_chan) begin
            chan_reg <= reg_wdata_i[3:0];
        end
    end

    // bandgap bit; every other bit of this register is unimplemented
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            bandgap_ctrl_reg <= `ASRCS_RST_BANDGAP;
        end else if (wr_bandgap) begin
            bandgap_ctrl_reg <= reg_wdata_i[`ASRCS_BG_BIT]; // R13
        end
    end

    // analog select per shared pin; a set bit hands the pin to the converter
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            pin_analog_reg <= {N_PINS{1'b0}};
        end else if (wr_pin_analog) begin
            pin_analog_reg <= reg_wdata_i[N_PINS-1:0]; // R14
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    // read mux; unmapped offsets and unimplemented bits read zero
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr_i)
            `ASRCS_OFF_SRC_REF_CLK: begin
                rdata_next = src_ref_clk_reg;
            end
            `ASRCS_OFF_CHAN: begin
                rdata_next = {4'h0, chan_reg};
            end
            `ASRCS_OFF_BANDGAP: begin
                rdata_next = {4'h0, bandgap_ctrl_reg, 3'h0}; // R13
            end
            `ASRCS_OFF_PIN_ANALOG: begin
                rdata_next = pin_analog_reg;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // read data registered, valid only in the cycle after the strobe, else zero
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // converter controls
    // ----------------------------------------------------------------
    // next values of the converter controls, worked out from the registers and the low-voltage reset request
    always @* begin
        input_mux_next = src_decode(input_source_select); // R1 R2 R3
        // pin switch only closes on external source, so the quarter-supply node stays clear
        if (input_mux_next == `ASRCS_MUX_EXT) begin
            analog_channel_pin_next = chan_decode(chan_reg); // R1 R4
        end else begin
            analog_channel_pin_next = 8'h00;
        end
        // two reference codes share the pin, so the decode has three outcomes
        reference_sel_next = ref_decode(reference_select); // R6 R7 R8
        // either requester keeps the bandgap alive; off only when both let go
        bandgap_enable_next = low_voltage_reset_en_i | bandgap_ctrl_reg; // R12
    end

    // input mux; registered so the analog side sees one clean change after the write
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            input_mux_sel_o <= `ASRCS_MUX_EXT;
        end else begin
            input_mux_sel_o <= input_mux_next; // R17
        end
    end

    // channel pin switch; opens in the same cycle the source leaves external
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            analog_channel_pin_o <= 8'h00;
        end else begin
            analog_channel_pin_o <= analog_channel_pin_next; // R17
        end
    end

    // reference switch
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            reference_sel_o <= `ASRCS_REFSEL_PIN;
        end else begin
            reference_sel_o <= reference_sel_next; // R17
        end
    end

    // bandgap enable; one cycle behind a change of the low-voltage reset request
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            bandgap_enable_o <= 1'b0;
        end else begin
            bandgap_enable_o <= bandgap_enable_next; // R12
        end
    end

    // ----------------------------------------------------------------
    // prescaler and pin overrides
    // ----------------------------------------------------------------
    // prescaler restarts on a field change so the first tick is never short
    asrcs_clk_div #(
        .SEL_W(3)
    ) u_div (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .div_sel_i(converter_clock_divider_select),
        .conv_clk_en_o(conv_clk_en_o)
    );

    // analog-selected pins lose driver, pull-high and digital input
    asrcs_pin_share #(
        .N_PINS(N_PINS)
    ) u_pins (
        .analog_sel_i(pin_analog_reg),
        .gpio_oe_n_i(gpio_oe_n_i),
        .gpio_dout_i(gpio_dout_i),
        .pullup_en_i(pullup_en_i),
        .pin_oe_n_o(pin_oe_n_o),
        .pin_dout_o(pin_dout_o),
        .pin_pullup_o(pin_pullup_o),
        .pin_digital_in_en_o(pin_digital_in_en_o)
    );
endmodule
`default_nettype wire

/* File: dv/asrcs_top_props.sv */
// assertion checker for the source, reference and clock select block
`default_nettype none
`include "asrcs_map.vh"
module asrcs_top_props #(parameter N_PINS = 8) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [`ASRCS_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic low_voltage_reset_en_i,
    input wire logic [N_PINS-1:0] gpio_oe_n_i,
    input wire logic [N_PINS-1:0] gpio_dout_i,
    input wire logic [N_PINS-1:0] pullup_en_i,
    input wire logic [N_PINS-1:0] pin_oe_n_o,
    input wire logic [N_PINS-1:0] pin_dout_o,
    input wire logic [N_PINS-1:0] pin_pullup_o,
    input wire logic [N_PINS-1:0] pin_digital_in_en_o,
    input wire logic [1:0] input_mux_sel_o,
    input wire logic [7:0] analog_channel_pin_o,
    input wire logic [1:0] reference_sel_o,
    input wire logic conv_clk_en_o,
    input wire logic bandgap_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] gap_reg;
    logic wr0;
    // cycles since the last converter clock pulse; a restart may double it
    always_ff @(posedge clk_sys_i)
        gap_reg <= (!resetn_i || conv_clk_en_o) ? 9'h000 : gap_reg + 9'h001;
    assign wr0 = reg_wr_i && reg_addr_i == `ASRCS_OFF_SRC_REF_CLK;
    function automatic logic [1:0] mux_of(input logic [7:0] d);
        mux_of = (d[7:5] == 3'h4) ? 2'h2 : (d[7:5] inside {[3'h1:3'h3]}) ? 2'h1 : 2'h0;
    endfunction
    function automatic logic [1:0] ref_of(input logic [7:0] d);
        ref_of = (d[4:3] == 2'h3) ? 2'h0 : d[4:3];
    endfunction
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    chk_src_decode: assert property (
        wr0 |-> ##2 input_mux_sel_o == mux_of($past(reg_wdata_i, 2))) else $error("source");
    chk_ref_decode: assert property (
        wr0 |-> ##2 reference_sel_o == ref_of($past(reg_wdata_i, 2))) else $error("reference");
    chk_pin_onehot: assert property (
        $onehot0(analog_channel_pin_o) && (analog_channel_pin_o & 8'h82) == 8'h00)
        else $error("pin switch");
    chk_pin_internal: assert property (
        input_mux_sel_o != 2'h0 |-> analog_channel_pin_o == 8'h00) else $error("pin on");
    chk_clk_undiv: assert property (
        wr0 && reg_wdata_i[2:0] == 3'h0 |-> ##6 conv_clk_en_o) else $error("clock");
    chk_clk_gap: assert property (gap_reg < 9'd300) else $error("clock gap");
    chk_bg_lvr: assert property (
        low_voltage_reset_en_i |=> bandgap_enable_o) else $error("bandgap");
    chk_bg_read: assert property (
        reg_rd_i && reg_addr_i == `ASRCS_OFF_BANDGAP |=> (reg_rdata_o & 8'hF7) == 8'h00)
        else $error("bandgap bits");
    chk_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("rdata");
    chk_pin_analog: assert property (
        (~pin_digital_in_en_o & (~pin_oe_n_o | pin_pullup_o | pin_dout_o)) == '0)
        else $error("analog pin");
    chk_pin_pass: assert property (
        (gpio_oe_n_i & ~pin_oe_n_o) == '0 && (pin_pullup_o & ~pullup_en_i) == '0)
        else $error("pin pass");
    cover property (wr0 && reg_wdata_i[7:5] == 3'h4);
    cover property (reg_rd_i && reg_addr_i == `ASRCS_OFF_BANDGAP);
    cover property (~pin_digital_in_en_o != '0);
endmodule
`default_nettype wire

/* File: dv/asrcs_core_model.sv */
// converter core model: measures the converter clock period
`default_nettype none
module asrcs_core_model (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic conv_clk_en_i,
    output logic [8:0] gap_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] cnt_reg;
    // the core steps on each enable; gap is cycles between two steps
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cnt_reg <= 9'h001;
            gap_o <= 9'h000;
        end else if (conv_clk_en_i) begin
            gap_o <= cnt_reg;
            cnt_reg <= 9'h001;
        end else
            cnt_reg <= cnt_reg + 9'h001;
    end
endmodule
`default_nettype wire

/* File: dv/asrcs_top_tb.sv */
// self-checking bench for the source, reference and clock select block
`default_nettype none
module asrcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, wr = 1'b0, rd = 1'b0, low_voltage_reset = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00, oe_n = 8'hF0, dout = 8'h0F, pu = 8'h33;
    logic [7:0] rdata, p_oe_n, p_dout, p_pu, p_din, pin;
    logic [1:0] mux, rsel;
    logic clk_en, bg;
    logic [8:0] gap, e;
    int failures = 0, check_count = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    asrcs_top i_asrcs_top (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .low_voltage_reset_en_i(low_voltage_reset), .gpio_oe_n_i(oe_n),
        .gpio_dout_i(dout), .pullup_en_i(pu), .pin_oe_n_o(p_oe_n), .pin_dout_o(p_dout),
        .pin_pullup_o(p_pu), .pin_digital_in_en_o(p_din), .input_mux_sel_o(mux),
        .analog_channel_pin_o(pin), .reference_sel_o(rsel), .conv_clk_en_o(clk_en),
        .bandgap_enable_o(bg));
    asrcs_core_model i_asrcs_core_model (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .conv_clk_en_i(clk_en), .gap_o(gap));
    task automatic chk(input string n, input logic [8:0] x, input logic [8:0] g);
        check_count++;
        if (g !== x) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    // every access leaves one idle cycle so a strobe is never set twice at one edge
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        @(negedge clk_sys_i);
        chk("rdata", {1'b0, x}, {1'b0, rdata});
    endtask
    task automatic settle();
        repeat (2) @(negedge clk_sys_i);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog: the sequence needs about 980 cycles
    initial begin
        #50000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        for (int a = 0; a < 4; a++) rreg(a[3:0], 8'h00);
        for (int s = 0; s < 8; s++) begin
            // park the channel on a missing code before leaving the external source
            if (s inside {[1:4]}) wreg(4'h1, 8'h08);
            wreg(4'h0, {s[2:0], 5'h00});
            if (!(s inside {[1:4]})) wreg(4'h1, 8'h02);
            settle();
            e = (s == 4) ? 9'h002 : (s inside {[1:3]}) ? 9'h001 : 9'h000;
            chk("mux", e, {7'h00, mux});
            chk("pin", (e == 9'h000) ? 9'h004 : 9'h000, {1'b0, pin});
        end
        for (int c = 0; c < 16; c++) begin
            wreg(4'h1, {4'h0, c[3:0]});
            settle();
            e = (c < 8 && c != 1 && c != 7) ? 9'h001 << c : 9'h000;
            chk("pin", e, {1'b0, pin});
        end
        // channel is now 1111, so the quarter supply may be chosen
        for (int r = 0; r < 4; r++) begin
            // pin 7 stands in for the shared reference pin
            if (r == 1) wreg(4'h3, 8'h00);
            wreg(4'h0, {3'h4, r[1:0], 3'h0});
            if (r == 0 || r == 3) wreg(4'h3, 8'h80);
            settle();
            chk("ref", (r == 3) ? 9'h000 : 9'(r), {7'h00, rsel});
            chk("ref_pin", (r == 1 || r == 2) ? 9'h001 : 9'h000, {8'h00, p_din[7]});
        end
        rreg(4'h0, 8'h98);
        for (int k = 0; k < 8; k++) begin
            wreg(4'h0, {5'h00, k[2:0]});
            repeat ((3 << k) + 6) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            chk("gap", 9'h001 << k, gap);
        end
        wreg(4'h2, 8'hFF);
        rreg(4'h2, 8'h08);
        for (int b = 0; b < 4; b++) begin
            wreg(4'h2, {4'h0, b[0], 3'h0});
            low_voltage_reset <= b[1];
            settle();
            chk("bandgap", 9'(b != 0), {8'h00, bg});
        end
        wreg(4'h3, 8'h5A);
        settle();
        chk("oe_n", 9'h0FA, {1'b0, p_oe_n});
        chk("dout", 9'h005, {1'b0, p_dout});
        chk("pullup", 9'h021, {1'b0, p_pu});
        chk("din_en", 9'h0A5, {1'b0, p_din});
        rreg(4'h3, 8'h5A);
        wreg(4'hF, 8'hFF);
        rreg(4'hF, 8'h00);
        rreg(4'h0, 8'h07);
        end_of_test();
    end
endmodule
bind asrcs_top asrcs_top_props #(.N_PINS(N_PINS)) i_asrcs_top_props (.*);
`default_nettype wire
